//--- include/pad_pkg.sv
// Constants for the pad multiplexer and pad configuration block.
// Assumes a 32-bit APB register bus on pclk.
package pad_pkg;
	localparam int NUM_PADS = 14;
	localparam int NUM_PERIPH = 8;
	localparam int SEL_W = 4;
	localparam logic [SEL_W-1:0] SEL_NONE = 4'hF;
	// Register byte offsets
	localparam logic [11:0] OFF_IN = 12'h000;
	localparam logic [11:0] OFF_OUT = 12'h004;
	localparam logic [11:0] OFF_OE = 12'h008;
	localparam logic [11:0] OFF_IRQ_STAT = 12'h00C;
	localparam logic [11:0] OFF_IRQ_MASK = 12'h010;
	localparam logic [11:0] OFF_IRQ_MODE = 12'h014;
	localparam logic [11:0] OFF_IRQ_POL = 12'h018;
	localparam logic [11:0] OFF_HOLD = 12'h01C;
	localparam logic [11:0] OFF_PAD_CFG = 12'h040;
	localparam logic [11:0] OFF_ROUTE_IN = 12'h080;
	localparam logic [11:0] OFF_ROUTE_OUT = 12'h0C0;
	// Pad configuration word fields
	localparam int CFG_FUNC_LSB = 0;
	localparam int CFG_IE_BIT = 2;
	localparam int CFG_WPU_BIT = 3;
	localparam int CFG_WPD_BIT = 4;
	localparam int CFG_OEF_BIT = 5;
	localparam int CFG_W = 6;
	typedef enum logic [1:0] {
		FUNC_ZERO = 2'b00,
		FUNC_ONE = 2'b01,
		FUNC_TWO = 2'b10,
		FUNC_BAD = 2'b11
	} func_t;
	// Reset codes per pad
	localparam logic [2:0] RST_CODE [NUM_PADS] = '{3'h0, 3'h0, 3'h1, 3'h1, 3'h1, 3'h1,
		3'h5, 3'h1, 3'h1, 3'h3, 3'h1, 3'h0, 3'h3, 3'h4};
	// Pads whose function 2 is a serial line; others list none
	localparam logic [NUM_PADS-1:0] HAS_F2 = 14'h04F4;
	// Pads whose function 0 is a debug signal
	localparam logic [NUM_PADS-1:0] IS_DEBUG = 14'h00F0;
	localparam int DEBUG_CLK_PAD = 6;
	localparam int PERIPH_F2_W = 6;
endpackage

//--- rtl/pad_cell.sv
// One pad's function select, pull control and hold latch.
// Assumes synchronised pad input and configuration from the top.
`timescale 1ns/1ps
`default_nettype none
module pad_cell (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [pad_pkg::CFG_W-1:0] cfg,
	input wire logic [pad_pkg::CFG_W-1:0] cfg_rst,
	input wire logic init,
	input wire logic hold,
	input wire logic has_f2,
	input wire logic gpio_out,
	input wire logic gpio_oe,
	input wire logic dbg_out,
	input wire logic dbg_oe,
	input wire logic f2_out,
	input wire logic f2_oe,
	input wire logic matrix_out,
	input wire logic matrix_oe,
	input wire logic matrix_en,
	output logic pad_o,
	output logic pad_oe,
	output logic pad_wpu,
	output logic pad_wpd,
	output logic pad_ie
);
	import pad_pkg::*;
	func_t func;
	logic next_o, next_oe;
	assign func = func_t'(cfg[CFG_FUNC_LSB +: 2]);
	wire sel_f2_ok = (func == FUNC_TWO) && has_f2;
	// Matrix overrides the mux; unlisted function leaves the pad undriven unless CFG_OEF_BIT is set
	wire mux_o = (func == FUNC_ZERO) ? dbg_out : (func == FUNC_ONE) ? gpio_out :
		sel_f2_ok ? f2_out : 1'b0;
	wire mux_oe = (func == FUNC_ZERO) ? dbg_oe : (func == FUNC_ONE) ? gpio_oe :
		sel_f2_ok ? f2_oe : 1'b0;
	assign next_o = matrix_en ? matrix_out : mux_o;
	assign next_oe = (matrix_en ? matrix_oe : mux_oe) | cfg[CFG_OEF_BIT];
	////////////////////////////////////////////////////////////////
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pad_o <= 1'b0;
			pad_oe <= 1'b0;
			pad_wpu <= 1'b0;
			pad_wpd <= 1'b0;
			pad_ie <= 1'b0;
		end else if (init) begin
			// Strap-dependent reset image loaded once after release
			pad_o <= 1'b1;
			pad_oe <= cfg_rst[CFG_OEF_BIT];
			pad_wpu <= cfg_rst[CFG_WPU_BIT];
			pad_wpd <= cfg_rst[CFG_WPD_BIT];
			pad_ie <= cfg_rst[CFG_IE_BIT];
		end else if (!hold) begin
			pad_o <= next_o;
			pad_oe <= next_oe;
			pad_wpu <= cfg[CFG_WPU_BIT];
			pad_wpd <= cfg[CFG_WPD_BIT] & ~cfg[CFG_WPU_BIT];
			pad_ie <= cfg[CFG_IE_BIT];
		end
	end
endmodule
`default_nettype wire

//--- rtl/pad_mux_and_gpio_config.sv
// Top of the pad multiplexer, routing matrix and pad configuration.
// Assumes an APB master on pclk and raw asynchronous pad inputs.
//
// What this block does
// - Fourteen pads exist and registers choose what each one carries.
// - Each pad takes a pull-up, a pull-down or neither and may float.
// - The level of an input pad is readable through a register.
// - An input pad raises an interrupt on an edge or on a level.
// - Pads have separate input and output paths with an output enable.
// - A pad in hold keeps its configuration and level frozen.
// - A matrix links any peripheral input or output to any pad.
// - The pad mux chooses function 0, 1 or 2; debug pads offer debug, GPIO, serial.
// - Code 0 means input off and floating; code 1 input on and floating.
// - Code 2 means input on with pull-down; code 3 input on with pull-up.
// - Code 4 means output on with pull-up.
// - The debug clock pad resets pulled up unless the fuse disables pad debug.
// - Pads take codes 0, 3, 4, 5 or 1 after reset by position.
//
// The APB slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module pad_mux_and_gpio_config (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	input wire logic fuse_pad_debug_disable,
	input wire logic [pad_pkg::NUM_PADS-1:0] pad_i,
	output logic [pad_pkg::NUM_PADS-1:0] pad_o,
	output logic [pad_pkg::NUM_PADS-1:0] pad_oe,
	output logic [pad_pkg::NUM_PADS-1:0] pad_wpu,
	output logic [pad_pkg::NUM_PADS-1:0] pad_wpd,
	output logic [pad_pkg::NUM_PADS-1:0] pad_ie,
	input wire logic [3:0] dbg_out,
	input wire logic [3:0] dbg_oe,
	output logic [3:0] dbg_in,
	input wire logic [pad_pkg::PERIPH_F2_W-1:0] f2_out,
	input wire logic [pad_pkg::PERIPH_F2_W-1:0] f2_oe,
	output logic [pad_pkg::PERIPH_F2_W-1:0] f2_in,
	input wire logic [pad_pkg::NUM_PERIPH-1:0] periph_out,
	input wire logic [pad_pkg::NUM_PERIPH-1:0] periph_oe,
	output logic [pad_pkg::NUM_PERIPH-1:0] periph_in
);
	import pad_pkg::*;
	// Reset code to configuration word
	function automatic logic [CFG_W-1:0] code_cfg(input logic [2:0] code, input logic fuse);
		logic [CFG_W-1:0] c;
		c = '0;
		c[CFG_FUNC_LSB +: 2] = 2'b01;
		case (code)
			3'h0: c[CFG_IE_BIT] = 1'b0;
			3'h1: c[CFG_IE_BIT] = 1'b1;
			3'h2: begin
				c[CFG_IE_BIT] = 1'b1;
				c[CFG_WPD_BIT] = 1'b1;
			end
			3'h3: begin
				c[CFG_IE_BIT] = 1'b1;
				c[CFG_WPU_BIT] = 1'b1;
			end
			3'h4: begin
				c[CFG_OEF_BIT] = 1'b1;
				c[CFG_WPU_BIT] = 1'b1;
			end
			3'h5: begin
				c[CFG_IE_BIT] = 1'b1;
				c[CFG_WPU_BIT] = ~fuse;
			end
			default: c = '0;
		endcase
		return c;
	endfunction
	////////////////////////////////////////////////////////////////
	// Synchronisers for pads and fuse
	logic [NUM_PADS-1:0] sync1;
	logic [NUM_PADS-1:0] sync2;
	logic [NUM_PADS-1:0] sync_prev;
	logic fuse1;
	logic fuse2;
	logic init;
	logic init_done;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1 <= '0;
			sync2 <= '0;
			sync_prev <= '0;
		end else begin
			sync1 <= pad_i;
			sync2 <= sync1;
			sync_prev <= sync2;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fuse1 <= 1'b0;
			fuse2 <= 1'b0;
		end else begin
			fuse1 <= fuse_pad_debug_disable;
			fuse2 <= fuse1;
		end
	end
	// Fuse is caught two cycles after release, then the reset image loads
	logic [1:0] init_cnt;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			init_cnt <= 2'h0;
			init_done <= 1'b0;
		end else if (!init_done) begin
			init_cnt <= init_cnt + 2'h1;
			init_done <= (init_cnt == 2'h2);
		end
	end
	assign init = !init_done && (init_cnt == 2'h2);
	////////////////////////////////////////////////////////////////
	// Registers
	logic [CFG_W-1:0] cfg [NUM_PADS];
	logic [SEL_W-1:0] route_in [NUM_PERIPH];
	logic [SEL_W:0] route_out [NUM_PADS];
	logic [NUM_PADS-1:0] gpio_out;
	logic [NUM_PADS-1:0] gpio_oe;
	logic [NUM_PADS-1:0] irq_stat;
	logic [NUM_PADS-1:0] irq_mask;
	logic [NUM_PADS-1:0] irq_mode;
	logic [NUM_PADS-1:0] irq_pol;
	logic [NUM_PADS-1:0] hold;
	logic [NUM_PADS-1:0] out_rst;
	// One effect per transfer: writes land on the edge that completes it
	wire access = psel && penable;
	wire first_access = access && !pready;
	wire wr = access && pready && pwrite;
	wire [11:0] a = paddr;
	wire in_cfg = (a >= OFF_PAD_CFG) && (a < OFF_PAD_CFG + 12'h038) && (a[1:0] == 2'b00);
	wire in_rin = (a >= OFF_ROUTE_IN) && (a < OFF_ROUTE_IN + 12'h020) && (a[1:0] == 2'b00);
	wire in_rout = (a >= OFF_ROUTE_OUT) && (a < OFF_ROUTE_OUT + 12'h038) && (a[1:0] == 2'b00);
	wire [3:0] cfg_idx = 4'((a - OFF_PAD_CFG) >> 2);
	wire [3:0] rin_idx = 4'((a - OFF_ROUTE_IN) >> 2);
	wire [3:0] rout_idx = 4'((a - OFF_ROUTE_OUT) >> 2);
	wire hit_in = (a == OFF_IN);
	wire hit_out = (a == OFF_OUT);
	wire hit_oe = (a == OFF_OE);
	wire hit_stat = (a == OFF_IRQ_STAT);
	wire hit_mask = (a == OFF_IRQ_MASK);
	wire hit_mode = (a == OFF_IRQ_MODE);
	wire hit_pol = (a == OFF_IRQ_POL);
	wire hit_hold = (a == OFF_HOLD);
	wire hit_flat = hit_in || hit_out || hit_oe || hit_stat || hit_mask || hit_mode ||
		hit_pol || hit_hold;
	wire wr_out = wr && hit_out;
	wire wr_oe = wr && hit_oe;
	wire stat_wr = wr && hit_stat;
	wire wr_mask = wr && hit_mask;
	wire wr_mode = wr && hit_mode;
	wire wr_pol = wr && hit_pol;
	wire wr_hold = wr && hit_hold;
	wire hit = hit_flat || in_cfg || in_rin || in_rout;
	wire [NUM_PADS-1:0] w14 = pwdata[NUM_PADS-1:0];
	// Input level as software sees it; gated by the input buffer
	wire [NUM_PADS-1:0] in_lvl = sync2 & pad_ie;
	wire [NUM_PADS-1:0] prev_lvl = sync_prev & pad_ie;
	wire [NUM_PADS-1:0] rise_ev = in_lvl & ~prev_lvl;
	wire [NUM_PADS-1:0] fall_ev = ~in_lvl & prev_lvl;
	// Polarity is per pad, so the edge is picked bit by bit
	wire [NUM_PADS-1:0] edge_ev = (irq_pol & rise_ev) | (~irq_pol & fall_ev);
	wire [NUM_PADS-1:0] lvl_ev = ~(in_lvl ^ irq_pol);
	wire [NUM_PADS-1:0] ev = pad_ie & ((irq_mode & lvl_ev) | (~irq_mode & edge_ev));
	// Set wins over write-one-to-clear
	wire [NUM_PADS-1:0] next_stat = (irq_stat & ~(stat_wr ? w14 : '0)) | ev;
	wire next_irq = |(next_stat & irq_mask);
	////////////////////////////////////////////////////////////////
	// Interrupt status and control registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat <= '0;
		end else begin
			irq_stat <= next_stat;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gpio_out <= '0;
			gpio_oe <= '0;
			irq_mask <= '0;
			irq_mode <= '0;
			irq_pol <= '0;
			hold <= '0;
		end else begin
			if (wr_out) gpio_out <= w14;
			if (init) gpio_out <= out_rst;
			if (wr_oe) gpio_oe <= w14;
			if (wr_mask) irq_mask <= w14;
			if (wr_mode) irq_mode <= w14;
			if (wr_pol) irq_pol <= w14;
			if (wr_hold) hold <= w14;
		end
	end
	genvar g;
	generate
		for (g = 0; g < NUM_PADS; g++) begin : g_cfg
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					cfg[g] <= '0;
					route_out[g] <= '0;
				end else if (init) begin
					cfg[g] <= code_cfg(RST_CODE[g], fuse2);
				end else begin
					if (wr && in_cfg && cfg_idx == 4'(g) && !hold[g]) cfg[g] <= pwdata[CFG_W-1:0];
					if (wr && in_rout && rout_idx == 4'(g)) route_out[g] <= pwdata[SEL_W:0];
				end
			end
		end
		for (g = 0; g < NUM_PERIPH; g++) begin : g_rin
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					route_in[g] <= SEL_NONE;
				end else if (wr && in_rin && rin_idx == 4'(g)) begin
					route_in[g] <= pwdata[SEL_W-1:0];
				end
			end
		end
	endgenerate
	////////////////////////////////////////////////////////////////
	// Pad cells
	logic [NUM_PADS-1:0] cell_dbg_o;
	logic [NUM_PADS-1:0] cell_dbg_oe;
	logic [NUM_PADS-1:0] cell_f2_o;
	logic [NUM_PADS-1:0] cell_f2_oe;
	logic [NUM_PADS-1:0] mx_o;
	logic [NUM_PADS-1:0] mx_oe;
	logic [NUM_PADS-1:0] mx_en;
	generate
		for (g = 0; g < NUM_PADS; g++) begin : g_pad
			localparam int DI = (g >= 4 && g < 8) ? g - 4 : 0;
			localparam int FI = (g == 2) ? 0 : (g >= 4 && g < 8) ? g - 3 : (g == 10) ? 5 : 0;
			wire [SEL_W-1:0] osel = route_out[g][SEL_W-1:0];
			assign cell_dbg_o[g] = IS_DEBUG[g] ? dbg_out[DI] : gpio_out[g];
			assign cell_dbg_oe[g] = IS_DEBUG[g] ? dbg_oe[DI] : gpio_oe[g];
			assign cell_f2_o[g] = HAS_F2[g] ? f2_out[FI] : 1'b0;
			assign cell_f2_oe[g] = HAS_F2[g] ? f2_oe[FI] : 1'b0;
			assign mx_en[g] = route_out[g][SEL_W];
			assign mx_o[g] = (osel < 4'(NUM_PERIPH)) ? periph_out[osel[2:0]] : 1'b0;
			assign mx_oe[g] = (osel < 4'(NUM_PERIPH)) ? periph_oe[osel[2:0]] : 1'b0;
			// Code 4 pad keeps driving high after init through its output bit
			assign out_rst[g] = (RST_CODE[g] == 3'h4);
			pad_cell u_cell (
				.pclk(pclk),
				.presetn(presetn),
				.cfg(cfg[g]),
				.cfg_rst(code_cfg(RST_CODE[g], fuse2)),
				.init(init),
				.hold(hold[g]),
				.has_f2(HAS_F2[g]),
				.gpio_out(gpio_out[g]),
				.gpio_oe(gpio_oe[g]),
				.dbg_out(cell_dbg_o[g]),
				.dbg_oe(cell_dbg_oe[g]),
				.f2_out(cell_f2_o[g]),
				.f2_oe(cell_f2_oe[g]),
				.matrix_out(mx_o[g]),
				.matrix_oe(mx_oe[g]),
				.matrix_en(mx_en[g]),
				.pad_o(pad_o[g]),
				.pad_oe(pad_oe[g]),
				.pad_wpu(pad_wpu[g]),
				.pad_wpd(pad_wpd[g]),
				.pad_ie(pad_ie[g])
			);
		end
	endgenerate
	////////////////////////////////////////////////////////////////
	// Peripheral inputs
	function automatic logic [1:0] fsel(input logic [CFG_W-1:0] c);
		return c[CFG_FUNC_LSB +: 2];
	endfunction
	logic [3:0] next_dbg_in;
	logic [PERIPH_F2_W-1:0] next_f2_in;
	logic [NUM_PERIPH-1:0] next_periph_in;
	generate
		for (g = 0; g < 4; g++) begin : g_dbgin
			assign next_dbg_in[g] = (fsel(cfg[g+4]) == 2'b00) ? in_lvl[g+4] : 1'b0;
		end
		assign next_f2_in[0] = (fsel(cfg[2]) == 2'b10) ? in_lvl[2] : 1'b0;
		for (g = 1; g < 5; g++) begin : g_f2in
			assign next_f2_in[g] = (fsel(cfg[g+3]) == 2'b10) ? in_lvl[g+3] : 1'b0;
		end
		assign next_f2_in[5] = (fsel(cfg[10]) == 2'b10) ? in_lvl[10] : 1'b0;
		for (g = 0; g < NUM_PERIPH; g++) begin : g_pin
			// Unrouted peripheral input sees a constant low
			assign next_periph_in[g] = (route_in[g] < 4'(NUM_PADS)) ?
				in_lvl[route_in[g]] : 1'b0;
		end
	endgenerate
	////////////////////////////////////////////////////////////////
	// APB read path, ready and error response
	logic [31:0] rd;
	always_comb begin
		rd = 32'h0000_0000;
		if (in_cfg && cfg_idx < 4'(NUM_PADS)) rd = 32'(cfg[cfg_idx]);
		else if (in_rin && rin_idx < 4'(NUM_PERIPH)) rd = 32'(route_in[rin_idx[2:0]]);
		else if (in_rout && rout_idx < 4'(NUM_PADS)) rd = 32'(route_out[rout_idx]);
		else if (a == OFF_IN) rd = 32'(in_lvl);
		else if (a == OFF_OUT) rd = 32'(gpio_out);
		else if (a == OFF_OE) rd = 32'(gpio_oe);
		else if (a == OFF_IRQ_STAT) rd = 32'(irq_stat);
		else if (a == OFF_IRQ_MASK) rd = 32'(irq_mask);
		else if (a == OFF_IRQ_MODE) rd = 32'(irq_mode);
		else if (a == OFF_IRQ_POL) rd = 32'(irq_pol);
		else if (a == OFF_HOLD) rd = 32'(hold);
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			// One wait state: answer registered in the first access cycle
			pready <= first_access;
			pslverr <= first_access && !hit;
			prdata <= (psel && !pwrite) ? rd : 32'h0000_0000;
		end
	end
	////////////////////////////////////////////////////////////////
	// Pad-side outputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
			dbg_in <= '0;
			f2_in <= '0;
			periph_in <= '0;
		end else begin
			irq <= next_irq;
			dbg_in <= next_dbg_in;
			f2_in <= next_f2_in;
			periph_in <= next_periph_in;
		end
	end
endmodule
`default_nettype wire

//--- sim/pad_board.sv
// Board model: resolves each pad from chip drive, board drive and pulls.
// Assumes the bench chooses which pads the board drives.
`timescale 1ns/1ps
`default_nettype none
module pad_board (
	input wire logic [13:0] pad_o,
	input wire logic [13:0] pad_oe,
	input wire logic [13:0] pad_wpu,
	input wire logic [13:0] pad_wpd,
	input wire logic [13:0] board_en,
	input wire logic [13:0] board_val,
	output logic [13:0] pad_i
);
	always_comb begin
		for (int i = 0; i < 14; i++) begin
			if (pad_oe[i])
				pad_i[i] = pad_o[i];
			else if (board_en[i])
				pad_i[i] = board_val[i];
			else if (pad_wpu[i] | pad_wpd[i])
				pad_i[i] = pad_wpu[i];
			else
				pad_i[i] = ~pad_o[i]; // Floating: no stale level
		end
	end
endmodule
`default_nettype wire

//--- sim/pad_mux_and_gpio_config_properties.sv
// Port-level assertions for the pad block.
// Assumes no register write in the first six edges after reset.
`timescale 1ns/1ps
`default_nettype none
module pad_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic irq,
	input wire logic fuse_pad_debug_disable,
	input wire logic [pad_pkg::NUM_PADS-1:0] pad_o,
	input wire logic [pad_pkg::NUM_PADS-1:0] pad_wpu,
	input wire logic [pad_pkg::NUM_PADS-1:0] pad_wpd,
	input wire logic [pad_pkg::NUM_PADS-1:0] pad_oe,
	input wire logic [pad_pkg::NUM_PADS-1:0] pad_ie
);
	import pad_pkg::*;
	logic [2:0] cnt;
	logic [NUM_PADS-1:0] held;
	logic [NUM_PADS-1:0] mask;
	wire wr_hit = psel & penable & pready & pwrite;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	////////////////////////////////////////////////////////////////
	// Shadows of hold and mask, edge count since reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= 3'h0;
			held <= 14'h0;
			mask <= 14'h0;
		end else begin
			if (cnt != 3'h7)
				cnt <= cnt + 3'h1;
			if (wr_hit && paddr == OFF_HOLD)
				held <= pwdata[13:0];
			if (wr_hit && paddr == OFF_IRQ_MASK)
				mask <= pwdata[13:0];
		end
	end
	////////////////////////////////////////////////////////////////
	property p_ready_after;
		psel && $rose(penable) |=> pready;
	endproperty
	a_ready_after: assert property (p_ready_after) else $error("pready late");
	property p_ready_pulse;
		pready |=> !pready;
	endproperty
	a_ready_pulse: assert property (p_ready_pulse) else $error("pready long");
	property p_pull_excl;
		(pad_wpu & pad_wpd) == 14'h0;
	endproperty
	a_pull_excl: assert property (p_pull_excl) else $error("both pulls on");
	property p_reset_oe;
		cnt == 3'h5 |-> pad_oe == 14'h2000 && pad_o[13];
	endproperty
	a_reset_oe: assert property (p_reset_oe) else $error("reset drive wrong");
	property p_reset_pull;
		cnt == 3'h5 |-> (pad_wpu & 14'h3FBF) == 14'h3200 && pad_wpd == 14'h0
			&& pad_wpu[6] == !fuse_pad_debug_disable;
	endproperty
	a_reset_pull: assert property (p_reset_pull) else $error("reset pulls wrong");
	property p_reset_ie;
		cnt == 3'h5 |-> (pad_ie & 14'h1FFF) == 14'h17FC;
	endproperty
	a_reset_ie: assert property (p_reset_ie) else $error("reset input wrong");
	property p_hold;
		((pad_o ^ $past(pad_o)) & held & $past(held)) == 14'h0;
	endproperty
	a_hold: assert property (p_hold) else $error("held pad moved");
	property p_irq_mask;
		mask == 14'h0 && $past(mask) == 14'h0 |-> !irq;
	endproperty
	a_irq_mask: assert property (p_irq_mask) else $error("masked irq");
endmodule
bind pad_mux_and_gpio_config pad_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
	.paddr, .pwdata, .pready, .irq, .fuse_pad_debug_disable, .pad_o, .pad_wpu, .pad_wpd,
	.pad_oe, .pad_ie);
`default_nettype wire

//--- sim/pad_mux_and_gpio_config_tb_top.sv
// Bench for the pad block: APB tasks and directed pad tests.
// Assumes the board model and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module pad_mux_and_gpio_config_tb_top;
	import pad_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0;
	logic fuse_pad_debug_disable = 1'b0;
	logic [3:0] dbg_out = 4'h0;
	logic [3:0] dbg_oe = 4'h0;
	logic [5:0] f2_out = 6'h02;
	logic [5:0] f2_oe = 6'h02;
	logic [7:0] periph_out = 8'h0;
	logic [7:0] periph_oe = 8'h0;
	logic [13:0] board_en = 14'h8;
	logic [13:0] board_val = 14'h0;
	logic [31:0] prdata, rdat;
	logic pready, pslverr, irq, serr;
	logic [13:0] pad_i, pad_o, pad_oe, pad_wpu, pad_wpd, pad_ie;
	logic [3:0] dbg_in;
	logic [5:0] f2_in;
	logic [7:0] periph_in;
	int bad_count = 0;
	int checked = 0;
	pad_mux_and_gpio_config dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .irq, .fuse_pad_debug_disable, .pad_i, .pad_o, .pad_oe,
		.pad_wpu, .pad_wpd, .pad_ie, .dbg_out, .dbg_oe, .dbg_in, .f2_out, .f2_oe, .f2_in,
		.periph_out, .periph_oe, .periph_in);
	pad_board board (.pad_o, .pad_oe, .pad_wpu, .pad_wpd, .board_en, .board_val, .pad_i);
	initial forever #5 pclk = ~pclk;
	////////////////////////////////////////////////////////////////
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			bad_count++;
			$display("unexpected %s: expected %h seen %h", s, e, g);
		end
	endtask
	// Holds the request until pready; an idle edge follows
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20)
			bad_count++;
		rdat = prdata;
		serr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask
	task automatic rd(input string s, input logic [11:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(s, e, rdat & 32'h8);
	endtask
	task automatic close_out();
		$display("mismatches %0d of %0d checks", bad_count, checked);
		if (bad_count == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (5000) @(posedge pclk);
		bad_count++;
		close_out();
	end
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		repeat (6) @(posedge pclk);
		chk("wpu", 32'h3240, 32'(pad_wpu));
		chk("wpd", 32'h0, 32'(pad_wpd));
		chk("ie", 32'h17FC, 32'(pad_ie & 14'h1FFF));
		chk("oe", 32'h2000, 32'(pad_oe));
		chk("tx high", 32'h1, 32'(pad_o[13]));
		presetn <= 1'b0;
		fuse_pad_debug_disable <= 1'b1;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		repeat (6) @(posedge pclk);
		chk("wpu fuse", 32'h3200, 32'(pad_wpu));
		$display("reset test done");
		wr(OFF_OE, 32'h11);
		wr(OFF_PAD_CFG, 32'h2);
		for (int f = 0; f < 4; f++) begin
			wr(OFF_PAD_CFG + 12'h010, 32'(f) | 32'h4);
			repeat (5) @(posedge pclk);
			chk("mux oe", 32'(f == 1 || f == 2), 32'(pad_oe[4]));
			chk("debug in", 32'(f == 0), 32'(dbg_in[0]));
			chk("serial in", 32'(f == 2), 32'(f2_in[1]));
			if (f == 1 || f == 2)
				chk("mux o", 32'(f == 2), 32'(pad_o[4]));
		end
		chk("no f2 oe", 32'h0, 32'(pad_oe[0]));
		for (int i = 0; i < 4; i++) begin
			wr(OFF_PAD_CFG + 12'h004, 32'(i * 8));
			repeat (3) @(posedge pclk);
			chk("pullup", 32'(i % 2), 32'(pad_wpu[1]));
			chk("pulldown", 32'(i == 2), 32'(pad_wpd[1]));
		end
		$display("mux and pull test done");
		wr(OFF_IRQ_MASK, 32'h8);
		wr(OFF_IRQ_POL, 32'h8);
		wr(OFF_IRQ_MODE, 32'h0);
		wr(OFF_IRQ_STAT, 32'h3FFF);
		rd("in low", OFF_IN, 32'h0);
		board_val <= 14'h8;
		repeat (5) @(posedge pclk);
		chk("irq edge", 32'h1, 32'(irq));
		rd("in high", OFF_IN, 32'h8);
		rd("stat", OFF_IRQ_STAT, 32'h8);
		wr(OFF_IRQ_STAT, 32'h8);
		repeat (2) @(posedge pclk);
		chk("irq clear", 32'h0, 32'(irq));
		wr(OFF_IRQ_MODE, 32'h8);
		wr(OFF_IRQ_STAT, 32'h8);
		repeat (2) @(posedge pclk);
		chk("irq level", 32'h1, 32'(irq));
		wr(OFF_IRQ_MASK, 32'h0);
		repeat (2) @(posedge pclk);
		chk("irq masked", 32'h0, 32'(irq));
		wr(OFF_IRQ_MODE, 32'h0);
		wr(OFF_IRQ_POL, 32'h1);
		wr(OFF_IRQ_STAT, 32'h3FFF);
		wr(OFF_IRQ_MASK, 32'h8);
		$display("input and irq test done");
		periph_out <= 8'h08;
		periph_oe <= 8'h08;
		wr(OFF_ROUTE_OUT + 12'h008, 32'h13);
		wr(OFF_ROUTE_IN + 12'h014, 32'h3);
		repeat (4) @(posedge pclk);
		chk("route out", 32'h3, 32'({pad_oe[2], pad_o[2]}));
		chk("route in", 32'h1, 32'(periph_in[5]));
		chk("irq no rise", 32'h0, 32'(irq));
		board_val <= 14'h0;
		repeat (5) @(posedge pclk);
		chk("route in low", 32'h0, 32'(periph_in[5]));
		chk("irq fall", 32'h1, 32'(irq));
		$display("matrix test done");
		wr(OFF_PAD_CFG + 12'h010, 32'h1);
		wr(OFF_OUT, 32'h10);
		wr(OFF_HOLD, 32'h10);
		wr(OFF_OUT, 32'h0);
		wr(OFF_PAD_CFG + 12'h010, 32'h3);
		repeat (3) @(posedge pclk);
		chk("held", 32'h3, 32'({pad_oe[4], pad_o[4]}));
		wr(OFF_HOLD, 32'h0);
		repeat (3) @(posedge pclk);
		chk("released", 32'h2, 32'({pad_oe[4], pad_o[4]}));
		xfer(1'b0, 12'hFFC, 32'h0);
		chk("slverr", 32'h1, 32'(serr));
		chk("unmapped read", 32'h0, rdat);
		$display("hold and map test done");
		close_out();
	end
endmodule
`default_nettype wire
